// ==== logic/netproc_host_transport.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "netproc_regs.svh"

module netproc_host_transport (
  input  wire logic       clk_sys,         // System clock, 250 MHz
  input  wire logic       sys_rst,         // Synchronous reset, active high
  input  wire logic       ce,              // Clock enable
  input  wire logic       sclk,            // SPI serial clock pin
  input  wire logic       mosi,            // SPI host-to-device data pin
  input  wire logic       csN,             // SPI chip select, active low
  input  wire logic       hostReadyN,      // Host-ready, active low
  output logic            misoOut,         // SPI device-to-host data
  output logic            misoOe,          // MISO output enable
  output logic            slaveReady,      // Bi-modal slave-ready pin
  input  wire logic       uartRx,          // UART receive pin
  output logic            uartTx,          // UART transmit pin
  output logic            uartRtsN,        // UART request to send, active low
  input  wire logic       uartCtsN,        // UART clear to send, active low
  input  wire logic       transportStrap,  // Transport-select strap pin
  input  wire logic       crystalStrap,    // Crystal-present strap pin
  output logic            spiMode,         // SPI transport selected
  output logic            crystalPresent,  // External sleep crystal fitted
  output logic [7:0]      rxData,          // Received byte
  output logic            rxValid,         // Received byte held
  input  wire logic       rxReady,         // User takes received byte
  input  wire logic       rxFrameDone,     // User: inbound frame complete
  input  wire logic [1:0] rxFrameKind,     // User: kind of completed frame
  input  wire logic       respReady,       // User: reply frame prepared
  input  wire logic       asyncPending,    // User: outbound async frame held
  input  wire logic [7:0] txData,          // Byte to send
  input  wire logic       txValid,         // Byte to send offered
  output logic            txReady,         // Byte to send taken
  output logic            overflow,        // Receive overflow pulse
  output logic            resetIndPending  // Reset indication not yet fetched
);
  localparam int NPIN = 6;

  function automatic logic edgeUp(input logic now, input logic prev);
    return now & ~prev;
  endfunction

  logic [NPIN-1:0]          pinMeta;
  logic [NPIN-1:0]          pinSync;
  logic                     sclkS;
  logic                     mosiS;
  logic                     csS;
  logic                     hrS;
  logic                     sclkPrev;
  logic                     csPrev;
  logic                     hrPrev;
  logic                     strapDone;
  logic                     sclkRise;
  logic                     sclkFall;
  logic                     csFall;
  logic                     hrFall;
  logic                     byteDone;
  logic                     loadTx;
  logic                     spiTxTake;
  logic [2:0]               bitCnt;
  logic [7:0]               rxShift;
  logic [7:0]               txShift;
  logic                     spiRxValid;
  logic [7:0]               spiRxData;
  logic                     ovf;
  logic                     pendOut;
  logic                     lastPoll;
  netproc_pkg::link_state_e state;
  netproc_pkg::link_state_e next_state;
  logic                     next_slaveReady;
  logic [7:0]               uRxData;
  logic                     uRxValid;
  logic                     uTxReady;

  // Two-stage synchroniser for every pin input but uartRx and uartCtsN, which uart_link synchronises
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      pinMeta <= {sclk, mosi, csN, hostReadyN, transportStrap, crystalStrap};
      pinSync <= pinMeta;
    end
  end
  assign sclkS = pinSync[5];
  assign mosiS = pinSync[4];
  assign csS   = pinSync[3];
  assign hrS   = pinSync[2];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sclkPrev <= 1'b0;
      csPrev   <= 1'b1;
      hrPrev   <= 1'b1;
    end else if (ce) begin
      sclkPrev <= sclkS;
      csPrev   <= csS;
      hrPrev   <= hrS;
    end
  end

  // Straps caught once, on the first enabled edge after reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      strapDone      <= 1'b0;
      spiMode        <= 1'b0;
      crystalPresent <= 1'b0;
    end else if (ce && !strapDone) begin
      strapDone      <= 1'b1;
      spiMode        <= pinSync[1];
      crystalPresent <= pinSync[0];
    end
  end

  // Oversampled at 250 MHz; clocks up to 4 MHz leave ample margin
  assign sclkRise = edgeUp(sclkS, sclkPrev) & ~csS & spiMode;
  assign sclkFall = edgeUp(sclkPrev, sclkS) & ~csS & spiMode;
  assign csFall   = edgeUp(csPrev, csS) & spiMode;
  assign hrFall   = edgeUp(hrPrev, hrS);
  assign byteDone = sclkRise && (bitCnt == `NP_BIT_LAST);
  assign loadTx   = csFall | byteDone;

  // Bytes only shift out in reply state; elsewhere MISO carries zeros
  assign spiTxTake = loadTx && (state == netproc_pkg::ST_SEND) && txValid;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bitCnt  <= 3'h0;
      rxShift <= 8'h00;
    end else if (ce) begin
      if (csS) begin
        bitCnt <= 3'h0;
      end else if (sclkRise) begin
        rxShift <= {rxShift[6:0], mosiS};
        bitCnt  <= bitCnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      txShift <= `NP_ZERO_BYTE;
    else if (ce) begin
      if (loadTx)
        txShift <= spiTxTake ? txData : `NP_ZERO_BYTE;
      else if (csS)
        txShift <= `NP_ZERO_BYTE;
      else if (sclkFall && bitCnt != 3'h0)
        txShift <= {txShift[6:0], 1'b0};
    end
  end
  assign misoOut = txShift[7];
  assign misoOe  = spiMode & ~csS;

  // Holding register; a new byte wins over a same-cycle take
  assign ovf = byteDone && (state == netproc_pkg::ST_RECV)
               && spiRxValid && !rxReady;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      spiRxValid <= 1'b0;
      spiRxData  <= 8'h00;
      overflow   <= 1'b0;
    end else if (ce) begin
      overflow <= ovf;
      if (byteDone && state == netproc_pkg::ST_RECV && !ovf) begin
        spiRxValid <= 1'b1;
        spiRxData  <= {rxShift[6:0], mosiS};
      end else if (spiRxValid && rxReady) begin
        spiRxValid <= 1'b0;
      end
    end
  end

  // Reset indication is held until a poll reply has been read out
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      resetIndPending <= 1'b0;
      lastPoll        <= 1'b0;
    end else if (ce) begin
      if (!strapDone)
        resetIndPending <= pinSync[1];
      else if (state == netproc_pkg::ST_SEND && hrS && lastPoll)
        resetIndPending <= 1'b0;
      if (state == netproc_pkg::ST_RECV && rxFrameDone)
        lastPoll <= (rxFrameKind == netproc_pkg::KIND_POLL);
    end
  end
  assign pendOut = asyncPending | resetIndPending;

  always_comb begin
    next_state = state;
    case (state)
      netproc_pkg::ST_IDLE: begin
        if (hrFall && spiMode && strapDone)
          next_state = netproc_pkg::ST_WAIT;
      end
      netproc_pkg::ST_WAIT: begin
        if (hrS)
          next_state = netproc_pkg::ST_IDLE;
        else if (rxReady)
          next_state = netproc_pkg::ST_RECV;
      end
      netproc_pkg::ST_RECV: begin
        if (ovf)
          next_state = netproc_pkg::ST_FLUSH;
        else if (hrS)
          next_state = netproc_pkg::ST_IDLE;
        else if (rxFrameDone && rxFrameKind == netproc_pkg::KIND_ASYNC_REQUEST_FRAME)
          next_state = netproc_pkg::ST_DONE;
        else if (rxFrameDone)
          next_state = netproc_pkg::ST_PREP;
      end
      netproc_pkg::ST_PREP: begin
        if (hrS)
          next_state = netproc_pkg::ST_IDLE;
        else if (respReady)
          next_state = netproc_pkg::ST_SEND;
      end
      netproc_pkg::ST_SEND,
      netproc_pkg::ST_DONE,
      netproc_pkg::ST_FLUSH: begin
        if (hrS)
          next_state = netproc_pkg::ST_IDLE;
      end
      default: next_state = netproc_pkg::ST_IDLE;
    endcase
  end

  always_comb begin
    case (next_state)
      netproc_pkg::ST_IDLE,
      netproc_pkg::ST_WAIT: next_slaveReady = ~(pendOut & spiMode & strapDone);
      netproc_pkg::ST_RECV,
      netproc_pkg::ST_PREP: next_slaveReady = 1'b0;
      netproc_pkg::ST_SEND,
      netproc_pkg::ST_DONE,
      netproc_pkg::ST_FLUSH: next_slaveReady = 1'b1;
      default:              next_slaveReady = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state      <= netproc_pkg::ST_IDLE;
      slaveReady <= 1'b1;
    end else if (ce) begin
      state      <= next_state;
      slaveReady <= next_slaveReady;
    end
  end

  uart_link u_uart (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .ce      (ce),
    .enable  (strapDone & ~spiMode),
    .rxPin   (uartRx),
    .ctsN    (uartCtsN),
    .txPin   (uartTx),
    .rtsN    (uartRtsN),
    .rxData  (uRxData),
    .rxValid (uRxValid),
    .rxReady (rxReady & ~spiMode),
    .txData  (txData),
    .txValid (txValid & ~spiMode),
    .txReady (uTxReady)
  );

  assign rxData  = spiMode ? spiRxData : uRxData;
  assign rxValid = spiMode ? spiRxValid : uRxValid;
  assign txReady = spiMode ? spiTxTake : uTxReady;
endmodule

`default_nettype wire

// ==== logic/netproc_pkg.sv ====
package netproc_pkg;

  typedef enum logic [1:0] {
    KIND_ASYNC_REQUEST_FRAME = 2'b00,
    KIND_SYNC_REQUEST_FRAME = 2'b01,
    KIND_POLL = 2'b10
  } frame_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WAIT  = 3'b001,
    ST_RECV  = 3'b010,
    ST_PREP  = 3'b011,
    ST_SEND  = 3'b100,
    ST_DONE  = 3'b101,
    ST_FLUSH = 3'b110
  } link_state_e;

endpackage

// ==== logic/netproc_regs.svh ====
`ifndef NETPROC_REGS_SVH
`define NETPROC_REGS_SVH

`define NP_CLK_HZ      250000000
`define NP_UART_BAUD   115200
`define NP_UART_DIV    (`NP_CLK_HZ / `NP_UART_BAUD)
`define NP_UART_STOP   4'd9
`define NP_BIT_LAST    3'd7
`define NP_ZERO_BYTE   8'h00

`endif

// ==== logic/uart_link.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "netproc_regs.svh"

module uart_link #(
  parameter logic [11:0] DIV = 12'(`NP_UART_DIV)
) (
  input  wire logic       clk_sys,  // System clock
  input  wire logic       sys_rst,  // Synchronous reset
  input  wire logic       ce,       // Clock enable
  input  wire logic       enable,   // UART transport selected
  input  wire logic       rxPin,    // Serial receive pin
  input  wire logic       ctsN,     // Clear to send, active low
  output logic            txPin,    // Serial transmit pin
  output logic            rtsN,     // Request to send, active low
  output logic [7:0]      rxData,   // Received byte
  output logic            rxValid,  // Received byte held
  input  wire logic       rxReady,  // User takes byte
  input  wire logic [7:0] txData,   // Byte to send
  input  wire logic       txValid,  // Byte to send offered
  output logic            txReady   // Byte to send taken
);
  logic [1:0]  meta;
  logic [1:0]  sync;
  logic        rxS;
  logic        ctsS;
  logic        rxBusy;
  logic [11:0] rxCnt;
  logic [3:0]  rxBit;
  logic [7:0]  rxSh;
  logic        txBusy;
  logic [11:0] txCnt;
  logic [3:0]  txBit;
  logic [9:0]  txSh;

  always_ff @(posedge clk_sys) begin
    if (ce) begin
      meta <= {rxPin, ctsN};
      sync <= meta;
    end
  end
  assign rxS  = sync[1];
  assign ctsS = sync[0];

  // 8-N-1, LSB first, sampled mid-bit
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rxBusy  <= 1'b0;
      rxCnt   <= 12'h000;
      rxBit   <= 4'h0;
      rxSh    <= 8'h00;
      rxValid <= 1'b0;
      rxData  <= 8'h00;
    end else if (ce) begin
      if (rxValid && rxReady)
        rxValid <= 1'b0;
      if (!rxBusy) begin
        if (enable && !rxS) begin
          rxBusy <= 1'b1;
          rxCnt  <= DIV >> 1;
          rxBit  <= 4'h0;
        end
      end else if (rxCnt != 12'h000) begin
        rxCnt <= rxCnt - 12'h001;
      end else begin
        rxCnt <= DIV - 12'h001;
        rxBit <= rxBit + 4'h1;
        if (rxBit == 4'h0 && rxS) begin
          rxBusy <= 1'b0;
        end else if (rxBit == `NP_UART_STOP) begin
          rxBusy <= 1'b0;
          if (rxS && (!rxValid || rxReady)) begin
            rxValid <= 1'b1;
            rxData  <= rxSh;
          end
        end else if (rxBit != 4'h0) begin
          rxSh <= {rxS, rxSh[7:1]};
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      rtsN <= 1'b1;
    else if (ce)
      rtsN <= ~(enable & ~rxValid);
  end

  assign txReady = enable & ~txBusy & ~ctsS;
  assign txPin   = txSh[0];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      txBusy <= 1'b0;
      txCnt  <= 12'h000;
      txBit  <= 4'h0;
      txSh   <= 10'h3ff;
    end else if (ce) begin
      if (!txBusy) begin
        if (txValid && txReady) begin
          txBusy <= 1'b1;
          txSh   <= {1'b1, txData, 1'b0};
          txCnt  <= DIV - 12'h001;
          txBit  <= 4'h0;
        end
      end else if (txCnt != 12'h000) begin
        txCnt <= txCnt - 12'h001;
      end else begin
        txCnt <= DIV - 12'h001;
        txSh  <= {1'b1, txSh[9:1]};
        txBit <= txBit + 4'h1;
        if (txBit == `NP_UART_STOP)
          txBusy <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// ==== testbench/host_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_master (
  input  wire logic clk_sys,    // Bench clock
  input  wire logic misoOut,    // Device data out
  output logic      sclk,       // Serial clock, idle low
  output logic      mosi,       // Host data out
  output logic      csN,        // Chip select, active low
  output logic      hostReadyN  // Host-ready, active low
);
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    csN = 1'b1;
    hostReadyN = 1'b1;
  end
  // Half of a 160 ns serial clock period
  task automatic half();
    repeat (20) @(negedge clk_sys);
  endtask
  task automatic host_ready_n(input logic lvl);
    hostReadyN = lvl;
    half();
  endtask
  task automatic phase(input logic lvl);
    csN = lvl;
    if (lvl) mosi = ~mosi;
    half();
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      half();
      sclk = 1'b1;
      rx[i] = misoOut;
      half();
      sclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== testbench/netproc_host_transport_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module netproc_host_transport_checker (
  input wire logic       clk_sys,         // Clock
  input wire logic       sys_rst,         // Reset
  input wire logic       hostReadyN,      // Host-ready pin
  input wire logic       misoOut,         // Device data out
  input wire logic       misoOe,          // Data out enable
  input wire logic       slaveReady,      // Slave-ready pin
  input wire logic       uartTx,          // UART transmit
  input wire logic       uartRtsN,        // UART request to send
  input wire logic       uartCtsN,        // UART clear to send
  input wire logic       spiMode,         // SPI selected
  input wire logic       rxValid,         // Byte held
  input wire logic       rxReady,         // Byte taken
  input wire logic       rxFrameDone,     // Frame complete
  input wire logic [1:0] rxFrameKind,     // Frame kind
  input wire logic       respReady,       // Reply prepared
  input wire logic       txValid,         // Byte offered
  input wire logic       txReady,         // Byte taken
  input wire logic       overflow,        // Overflow pulse
  input wire logic       resetIndPending  // Reset indication held
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_sync_done;
    rxFrameDone && rxFrameKind != netproc_pkg::KIND_ASYNC_REQUEST_FRAME && !respReady;
  endsequence
  sequence s_reply_up;
    s_sync_done ##[1:100] $rose(respReady);
  endsequence

  a_ready_fall: assert property ($fell(hostReadyN) && spiMode && rxReady |-> ##[1:12] !slaveReady)
    else $error("slaveReady late after host request");
  a_miso_quiet: assert property (misoOe && !slaveReady |-> !misoOut)
    else $error("data out while receiving");
  a_async_request_frame_done: assert property (rxFrameDone && rxFrameKind == netproc_pkg::KIND_ASYNC_REQUEST_FRAME && !slaveReady
    |=> slaveReady)
    else $error("slaveReady not high after async frame");
  a_reply_hold: assert property (s_sync_done ##1 !respReady |-> !slaveReady)
    else $error("slaveReady high before reply");
  a_reply_ready: assert property (s_reply_up |-> ##[0:3] slaveReady)
    else $error("slaveReady not high after reply");
  a_ovf_ready: assert property (overflow |-> ##[0:1] slaveReady)
    else $error("slaveReady low on overflow");
  a_ovf_zero: assert property (overflow |=> (!misoOut) [*3])
    else $error("nonzero data after overflow");
  a_rts_full: assert property ((rxValid && !rxReady) [*3] |-> uartRtsN)
    else $error("request to send low while full");
  a_cts_gate: assert property (txValid && txReady && !spiMode |-> !$past(uartCtsN, 2))
    else $error("byte taken without clear to send");
  a_start_bit: assert property (txValid && txReady && !spiMode |=> ##[0:1] (!uartTx) [*8])
    else $error("start bit missing");
  a_reset_ind: assert property ($rose(resetIndPending) |=> !slaveReady)
    else $error("reset indication not announced");
endmodule

bind netproc_host_transport netproc_host_transport_checker chk_u (
  .clk_sys, .sys_rst, .hostReadyN, .misoOut, .misoOe, .slaveReady, .uartTx, .uartRtsN,
  .uartCtsN, .spiMode, .rxValid, .rxReady, .rxFrameDone, .rxFrameKind, .respReady,
  .txValid, .txReady, .overflow, .resetIndPending
);
`default_nettype wire

// ==== testbench/netproc_host_transport_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module netproc_host_transport_tb;
  logic       clk_sys, sys_rst, sclk, mosi, csN, hostReadyN, misoOut, misoOe;
  logic       slaveReady, uartRx, uartTx, uartRtsN, uartCtsN, transportStrap;
  logic       crystalStrap, spiMode, crystalPresent, rxValid, rxReady, rxFrameDone;
  logic       respReady, asyncPending, txValid, txReady, overflow, resetIndPending;
  logic [1:0] rxFrameKind;
  logic       ce;
  logic [7:0] rxData, txData;
  logic [7:0] rxq[$];
  int         error_cnt = 0;
  int         tests_run = 0;
  int         ovCnt = 0;

  netproc_host_transport dut_u (.clk_sys, .sys_rst, .ce, .sclk, .mosi, .csN,
    .hostReadyN, .misoOut, .misoOe, .slaveReady, .uartRx, .uartTx, .uartRtsN, .uartCtsN,
    .transportStrap, .crystalStrap, .spiMode, .crystalPresent, .rxData, .rxValid, .rxReady,
    .rxFrameDone, .rxFrameKind, .respReady, .asyncPending, .txData, .txValid, .txReady,
    .overflow, .resetIndPending);
  host_master hm_u (.clk_sys, .misoOut, .sclk, .mosi, .csN, .hostReadyN);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (rxValid === 1'b1 && rxReady === 1'b1) rxq.push_back(rxData);
    if (overflow === 1'b1) ovCnt++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_sr(input logic lvl);
    int n;
    n = 0;
    while (slaveReady !== lvl && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    chkb(slaveReady, lvl);
  endtask
  task automatic done_pulse(input logic [1:0] kind);
    @(negedge clk_sys);
    rxFrameDone = 1'b1;
    rxFrameKind = kind;
    @(negedge clk_sys);
    rxFrameDone = 1'b0;
  endtask
  task automatic do_reset(input logic strap, input logic xtal);
    @(negedge clk_sys);
    transportStrap = strap;
    crystalStrap = xtal;
    sys_rst = 1'b1;
    repeat (10) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (5) @(negedge clk_sys);
    chkb(spiMode, strap);
    chkb(crystalPresent, xtal);
    chkb(resetIndPending, strap);
    chkb(slaveReady, ~strap);
  endtask
  task automatic sync_xact(input logic [1:0] kind, input logic [7:0] rep);
    logic [7:0] got;
    hm_u.host_ready_n(1'b0);
    wait_sr(1'b0);
    hm_u.phase(1'b0);
    hm_u.xfer(8'h5a, got);
    hm_u.phase(1'b1);
    chk(got, 8'h00);
    done_pulse(kind);
    repeat (30) @(negedge clk_sys);
    chkb(slaveReady, 1'b0);
    txData = rep;
    txValid = 1'b1;
    respReady = 1'b1;
    wait_sr(1'b1);
    hm_u.phase(1'b0);
    hm_u.xfer(8'hc3, got);
    hm_u.phase(1'b1);
    txValid = 1'b0;
    chk(got, rep);
    repeat (300) @(negedge clk_sys);
    chkb(slaveReady, 1'b1);
    hm_u.host_ready_n(1'b1);
    respReady = 1'b0;
    chk(rxq.pop_front(), 8'h5a);
  endtask
  task automatic async_request_frame_xact();
    logic [7:0] got;
    hm_u.host_ready_n(1'b0);
    wait_sr(1'b0);
    hm_u.phase(1'b0);
    hm_u.xfer(8'ha5, got);
    chk(got, 8'h00);
    hm_u.xfer(8'h3c, got);
    hm_u.phase(1'b1);
    chkb(slaveReady, 1'b0);
    done_pulse(netproc_pkg::KIND_ASYNC_REQUEST_FRAME);
    @(negedge clk_sys);
    chkb(slaveReady, 1'b1);
    hm_u.host_ready_n(1'b1);
    chkb(slaveReady, 1'b1);
    chk(rxq.pop_front(), 8'ha5);
    chk(rxq.pop_front(), 8'h3c);
  endtask
  task automatic ovf_xact();
    logic [7:0] got;
    hm_u.host_ready_n(1'b0);
    wait_sr(1'b0);
    rxReady = 1'b0;
    hm_u.phase(1'b0);
    hm_u.xfer(8'h11, got);
    hm_u.xfer(8'h22, got);
    chkb(slaveReady, 1'b1);
    chk(8'(ovCnt), 8'h01);
    txData = 8'hff;
    txValid = 1'b1;
    hm_u.xfer(8'h33, got);
    chk(got, 8'h00);
    hm_u.phase(1'b1);
    txValid = 1'b0;
    rxReady = 1'b1;
    hm_u.host_ready_n(1'b1);
    rxq.delete();
  endtask
  task automatic uart_xact();
    logic [9:0] txf;
    logic [9:0] rxf;
    int         n;
    txf = {1'b1, 8'h4b, 1'b0};
    rxf = {1'b1, 8'hd2, 1'b0};
    n = 0;
    chkb(uartRtsN, 1'b0);
    txData = 8'h4b;
    txValid = 1'b1;
    rxReady = 1'b0;
    repeat (50) @(negedge clk_sys);
    chkb(txReady | ~uartTx, 1'b0);
    uartCtsN = 1'b0;
    while (txReady !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    chkb(txReady, 1'b1);
    @(negedge clk_sys);
    txValid = 1'b0;
    for (int i = 0; i < 10; i++) begin
      uartRx = rxf[i];
      repeat (1085) @(negedge clk_sys);
      chkb(uartTx, txf[i]);
      repeat (1085) @(negedge clk_sys);
    end
    chk(rxData, 8'hd2);
    chkb(uartRtsN, 1'b1);
    rxReady = 1'b1;
    repeat (5) @(negedge clk_sys);
    chkb(uartRtsN, 1'b0);
  endtask

  initial begin
    {sys_rst, uartRx, uartCtsN, rxReady} = 4'hf;
    {transportStrap, crystalStrap, rxFrameDone, respReady, asyncPending, txValid} = 6'h00;
    rxFrameKind = 2'h0;
    txData = 8'h00;
    ce = 1'b1;
    do_reset(1'b1, 1'b0);
    sync_xact(netproc_pkg::KIND_POLL, 8'he1);
    chkb(resetIndPending, 1'b0);
    asyncPending = 1'b1;
    wait_sr(1'b0);
    sync_xact(netproc_pkg::KIND_POLL, 8'h7e);
    asyncPending = 1'b0;
    sync_xact(netproc_pkg::KIND_SYNC_REQUEST_FRAME, 8'h96);
    async_request_frame_xact();
    ovf_xact();
    async_request_frame_xact();
    // Clock enable low freezes slave-ready against a new pending frame
    ce = 1'b0;
    asyncPending = 1'b1;
    repeat (20) @(negedge clk_sys);
    chkb(slaveReady, 1'b1);
    ce = 1'b1;
    wait_sr(1'b0);
    asyncPending = 1'b0;
    wait_sr(1'b1);
    do_reset(1'b0, 1'b1);
    uart_xact();
    close_out();
  end

  // Cut a hang short
  initial begin
    #400000;
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
